/* tppg_timer.sv */
/*
 16-bit up-counter in pulse generator mode with staged compare writes and input filter.
 Assumes cnt_tick_i is the prescaled source clock strobe and register strobes are one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: mode code 011 counts when run set
// R2: software keeps period above toggle compare
// R3: idle output equals initial level flop
// R4: run locks mode, irq enable, flop
// R5: toggle match drives inverse level
// R6: period match restores level, raises irq
// R7: one-shot clears run at period match
// R8: continuous clears counter at period match
// R9: run clear restores initial level
// R10: one-shot select writable while running
// R11: double buffer loads at period match
// R12: unbuffered writes apply at once
// R13: low byte staged, high byte commits
// R14: buffered reads return last written value
// R15: stopped writes update buffer and active
// R16: three equal samples pass level
// R17: filter on when field nonzero
// R18: software waits four intervals before start
// R19: filter field locked while running
// R20: intervals 2, 4, 256 clocks
// R21: low speed: 11 halves sub clock
// R22: run clear stops and zeroes counter
// R23: counter wraps all ones to zero
module tppg_timer
    import tppg_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i, // clock 125 MHz
    input wire logic arst_n_i, // async reset, active low
    input wire logic ce_i, // clock enable
    input wire logic cnt_tick_i, // selected source clock strobe
    input wire logic mode_wr_i, // mode register write strobe
    input wire logic [2:0] op_mode_field_i, // operating mode
    input wire logic ctrl_wr_i, // control register write strobe
    input wire logic run_bit_i, // run value
    input wire logic oneshot_select_i, // one-shot value
    input wire logic initial_level_flop_i, // initial level value
    input wire logic overflow_irq_enable_i, // overflow irq enable value
    input wire logic double_buffer_enable_i, // double buffer value
    input wire logic [1:0] filter_interval_field_i, // filter interval value
    input wire logic cmp_wr_low_i, // low-byte compare write
    input wire logic cmp_wr_high_i, // high-byte compare write
    input wire logic cmp_sel_i, // 0 period, 1 toggle
    input wire logic [7:0] cmp_wdata_i, // compare write byte
    input wire logic low_speed_i, // low-speed clock mode
    input wire logic sub_clock_tick_i, // sub clock strobe
    input wire logic timer_input_pin_i, // raw timer input pin
    output logic pulse_out_pin_o, // pulse output
    output logic timer_irq_o, // irq pulse, one cycle
    output logic run_bit_o, // run status
    output logic [2:0] op_mode_field_o, // mode readback
    output logic initial_level_flop_o, // level flop readback
    output logic overflow_irq_enable_o, // irq enable readback
    output logic oneshot_select_o, // one-shot readback
    output logic double_buffer_enable_o, // double buffer readback
    output logic [1:0] filter_interval_field_o, // filter field readback
    output logic [CNT_W-1:0] period_compare_o, // period readback
    output logic [CNT_W-1:0] toggle_compare_o, // toggle readback
    output logic [CNT_W-1:0] count_o, // counter value
    output logic filtered_input_o // filtered timer input
);
    typedef struct packed {
        logic [2:0] mode;
        logic run;
        logic oneshot;
        logic tff;
        logic ove;
        logic dbf;
        logic [1:0] nc;
        logic [7:0] stage;
        logic [CNT_W-1:0] per_buf;
        logic [CNT_W-1:0] tog_buf;
        logic [CNT_W-1:0] per_act;
        logic [CNT_W-1:0] tog_act;
        logic [CNT_W-1:0] cnt;
        logic out;
        logic irq;
    } tppg_st_s;
    tppg_st_s st_r, st_nxt;
    logic rst_sync1_r, rst_n;
    logic ppg_on, per_hit, tog_hit, stop_now, buf_mode;
    logic [CNT_W-1:0] wr_word;

    // reset release through two flops
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_n <= rst_sync1_r;
        end
    end

    tppg_filter u_filter (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .interval_i(st_r.nc),
        .low_speed_i(low_speed_i),
        .sub_clock_tick_i(sub_clock_tick_i),
        .pin_i(timer_input_pin_i),
        .filt_o(filtered_input_o)
    );

    assign ppg_on = st_r.run && (st_r.mode == TPPG_MODE_PPG); // R1
    assign per_hit = ppg_on && cnt_tick_i && (st_r.cnt == st_r.per_act);
    assign tog_hit = ppg_on && cnt_tick_i && (st_r.cnt == st_r.tog_act);
    assign buf_mode = st_r.dbf && st_r.run;
    assign wr_word = {cmp_wdata_i, st_r.stage};

    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        stop_now = 1'b0;
        // mode register only while stopped
        if (mode_wr_i && !st_r.run) begin // R4
            st_nxt.mode = op_mode_field_i;
        end
        if (ctrl_wr_i) begin
            st_nxt.run = run_bit_i;
            st_nxt.oneshot = oneshot_select_i; // R10
            st_nxt.dbf = double_buffer_enable_i;
            if (!st_r.run) begin // R4 R19
                st_nxt.tff = initial_level_flop_i;
                st_nxt.ove = overflow_irq_enable_i;
                st_nxt.nc = filter_interval_field_i;
            end
        end
        if (cmp_wr_low_i) begin // R13
            st_nxt.stage = cmp_wdata_i;
        end
        if (cmp_wr_high_i) begin // R13
            if (cmp_sel_i) begin
                st_nxt.tog_buf = wr_word;
                if (!buf_mode) begin // R12 R15
                    st_nxt.tog_act = wr_word;
                end
            end else begin
                st_nxt.per_buf = wr_word;
                if (!buf_mode) begin // R12 R15
                    st_nxt.per_act = wr_word;
                end
            end
        end
        if (ppg_on && cnt_tick_i) begin
            st_nxt.cnt = st_r.cnt + 1'b1; // R23
        end
        if (tog_hit) begin
            st_nxt.out = ~st_r.tff; // R5
        end
        if (per_hit) begin
            st_nxt.out = st_r.tff; // R6
            st_nxt.irq = 1'b1; // R6
            st_nxt.cnt = TPPG_CNT_RST; // R8
            if (st_r.dbf) begin // R11
                st_nxt.per_act = st_r.per_buf;
                st_nxt.tog_act = st_r.tog_buf;
            end
            // newest one-shot value decides, so a late 0 cancels the stop
            if ((ctrl_wr_i && st_r.run) ? oneshot_select_i : st_r.oneshot) begin // R7 R10
                stop_now = 1'b1;
            end
        end
        if (stop_now) begin
            st_nxt.run = 1'b0; // R7
        end
        if (!st_nxt.run) begin
            st_nxt.cnt = TPPG_CNT_RST; // R22
            st_nxt.out = st_nxt.tff; // R3 R9
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.per_buf <= TPPG_CMP_RST;
            st_r.tog_buf <= TPPG_CMP_RST;
            st_r.per_act <= TPPG_CMP_RST;
            st_r.tog_act <= TPPG_CMP_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign pulse_out_pin_o = st_r.out;
    assign timer_irq_o = st_r.irq;
    assign run_bit_o = st_r.run;
    assign op_mode_field_o = st_r.mode;
    assign initial_level_flop_o = st_r.tff;
    assign overflow_irq_enable_o = st_r.ove;
    assign oneshot_select_o = st_r.oneshot;
    assign double_buffer_enable_o = st_r.dbf;
    assign filter_interval_field_o = st_r.nc;
    assign period_compare_o = st_r.per_buf; // R14
    assign toggle_compare_o = st_r.tog_buf; // R14
    assign count_o = st_r.cnt;

    idle_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        !st_r.run |-> pulse_out_pin_o == st_r.tff) else $error("idle level wrong"); // R3
    lock_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && st_r.run |=> $stable(op_mode_field_o)) else $error("mode changed while running"); // R4
    tog_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && tog_hit && !per_hit && st_nxt.run |=> pulse_out_pin_o != st_r.tff)
        else $error("toggle level wrong"); // R5
    per_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && per_hit |=> timer_irq_o && pulse_out_pin_o == initial_level_flop_o)
        else $error("period match effect missing"); // R6
    oneshot_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && per_hit && st_r.oneshot && !ctrl_wr_i |=> !run_bit_o)
        else $error("one-shot did not stop"); // R7
    cont_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && per_hit && !st_r.oneshot && !ctrl_wr_i |=> run_bit_o && count_o == 16'h0000)
        else $error("continuous clear wrong"); // R8
    stop_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && $fell(run_bit_o) |-> count_o == 16'h0000) else $error("counter not zeroed"); // R22
    dbuf_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && buf_mode && !per_hit && !ctrl_wr_i |=> $stable(st_r.per_act))
        else $error("buffered compare applied early"); // R11
    nc_lock_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && st_r.run |=> $stable(filter_interval_field_o)) else $error("filter field changed"); // R19
    cmp_commit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && cmp_wr_high_i && !cmp_sel_i |=> period_compare_o == $past(wr_word))
        else $error("compare commit wrong"); // R13

    // counter only moves on a source tick; a stalled prescaler must freeze it
    count_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ce_i && !cnt_tick_i && st_r.run && !ctrl_wr_i |=> $stable(count_o))
        else $error("counter moved without tick"); // R1

    oneshot_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) per_hit && st_r.oneshot);
    cont_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) per_hit && !st_r.oneshot);
    toggle_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) tog_hit);
    dbuf_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) per_hit && st_r.dbf);
endmodule : tppg_timer
`default_nettype wire

/* tppg_pkg.sv */
/*
 Shared constants for the 16-bit pulse generator timer with input noise filter.
 Assumes a single system clock domain; the count enable comes from an external prescaler.
*/
package tppg_pkg;
    localparam logic [2:0] TPPG_MODE_PPG = 3'h3;
    localparam logic [15:0] TPPG_CNT_RST = 16'h0000;
    localparam logic [15:0] TPPG_CMP_RST = 16'hFFFF;
    localparam logic [1:0] TPPG_NC_OFF = 2'h0;
    localparam logic [1:0] TPPG_NC_2 = 2'h1;
    localparam logic [1:0] TPPG_NC_4 = 2'h2;
    localparam logic [1:0] TPPG_NC_256 = 2'h3;
    localparam logic [8:0] TPPG_DIV_2 = 9'h002;
    localparam logic [8:0] TPPG_DIV_4 = 9'h004;
    localparam logic [8:0] TPPG_DIV_256 = 9'h100;
    localparam logic [8:0] TPPG_DIV_SUB = 9'h002;
    localparam logic [1:0] TPPG_MATCH_RUNS = 2'h3;
endpackage : tppg_pkg

/* tppg_filter.sv */
/*
 Digital noise filter for the timer input pin.
 Assumes pin and sub-clock strobe are synchronous to core_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module tppg_filter
    import tppg_pkg::*;
(
    input wire logic core_clk_i, // clock
    input wire logic rst_n_i, // synchronised reset
    input wire logic ce_i, // clock enable
    input wire logic [1:0] interval_i, // filter interval field
    input wire logic low_speed_i, // low-speed clock mode
    input wire logic sub_clock_tick_i, // sub clock strobe
    input wire logic pin_i, // raw timer input
    output logic filt_o // filtered level
);
    typedef struct packed {
        logic [8:0] div;
        logic [1:0] cnt;
        logic cand;
        logic lvl;
        logic sub_half;
    } tppg_flt_s;
    tppg_flt_s st_r, st_nxt;
    logic [8:0] limit;
    logic tick;
    always_comb begin
        case (interval_i)
            TPPG_NC_2: limit = TPPG_DIV_2;
            TPPG_NC_4: limit = TPPG_DIV_4;
            default: limit = TPPG_DIV_256;
        endcase
    end
    always_comb begin
        st_nxt = st_r;
        tick = 1'b0;
        if (low_speed_i) begin
            // sub clock halved for code 11
            if (sub_clock_tick_i) begin
                st_nxt.sub_half = ~st_r.sub_half;
                tick = st_r.sub_half;
            end
        end else if (st_r.div + 9'h001 >= limit) begin
            st_nxt.div = 9'h000;
            tick = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 9'h001;
        end
        if (interval_i == TPPG_NC_OFF) begin // R17
            st_nxt.lvl = pin_i;
            st_nxt.cnt = 2'h0;
            st_nxt.div = 9'h000;
        end else if (low_speed_i && interval_i != TPPG_NC_256) begin // R21
            st_nxt.lvl = 1'b0;
            st_nxt.cnt = 2'h0;
        end else if (tick) begin // R16 R20
            if (pin_i != st_r.cand) begin
                st_nxt.cand = pin_i;
                st_nxt.cnt = 2'h1;
            end else if (st_r.cnt >= TPPG_MATCH_RUNS - 2'h1) begin
                st_nxt.lvl = st_r.cand;
                st_nxt.cnt = TPPG_MATCH_RUNS;
            end else begin
                st_nxt.cnt = st_r.cnt + 2'h1;
            end
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end
    assign filt_o = st_r.lvl;
endmodule : tppg_filter
`default_nettype wire

/* tppg_pin_model.sv */
/*
 Far side of the timer pins: drives the timer input pin, counts pulse output edges.
 Assumes one clock; the bench steers level and glitch after rising edges.
*/
`timescale 1ns/100ps
`default_nettype none
module tppg_pin_model (
    input wire logic core_clk_i, // clock
    input wire logic level_i, // steady pin level
    input wire logic glitch_i, // one-cycle inverse spike
    input wire logic pulse_i, // pulse output pin
    output logic pin_o, // timer input pin
    output logic [15:0] edges_o // pulse output transitions
);
    logic last_r;
    initial begin
        pin_o = 1'b0;
        edges_o = 16'h0000;
        last_r = 1'b0;
    end
    always @(posedge core_clk_i) begin
        pin_o <= glitch_i ? ~level_i : level_i;
        last_r <= pulse_i;
        if (last_r !== pulse_i) begin
            edges_o <= edges_o + 16'h0001;
        end
    end
endmodule : tppg_pin_model
`default_nettype wire

/* timer16_ppg_noise_filter_tb.sv */
/*
 Self-checking bench for the pulse generator timer and its input filter.
 Assumes tppg_timer and tppg_pin_model; prescaler tick held high.
*/
`timescale 1ns/100ps
`default_nettype none
module timer16_ppg_noise_filter_tb import tppg_pkg::*;;
    logic clk = 0, arst_n = 0, tick = 1, ce = 1, wr = 0, run = 0, os = 0, tff = 0, dbf = 0;
    logic lwr = 0, hwr = 0, sel = 0, ls = 0, stk = 0, lvl = 0, gl = 0, pin;
    logic [2:0] mode = 0, modeo;
    logic [1:0] nc = 0, nco;
    logic [7:0] wd = 0;
    logic pout, irq, runo, tffo, oveo, oso, dbfo, filt;
    logic [15:0] pco, tco, cnt, edges, e0;
    int error_cnt = 0, total_checks = 0, cyc = 0, t0, t1, t2;
    logic [1:0] fn[6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1};
    logic fls[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic fb[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int fe[6] = '{3, 7, 500, 0, 10, 5};
    int fl[6] = '{16, 30, 1100, 6, 80, 20};
    tppg_timer dut (.core_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .cnt_tick_i(tick),
        .mode_wr_i(wr), .op_mode_field_i(mode), .ctrl_wr_i(wr), .run_bit_i(run),
        .oneshot_select_i(os), .initial_level_flop_i(tff), .overflow_irq_enable_i(tff),
        .double_buffer_enable_i(dbf), .filter_interval_field_i(nc), .cmp_wr_low_i(lwr),
        .cmp_wr_high_i(hwr), .cmp_sel_i(sel), .cmp_wdata_i(wd), .low_speed_i(ls),
        .sub_clock_tick_i(stk), .timer_input_pin_i(pin), .pulse_out_pin_o(pout),
        .timer_irq_o(irq), .run_bit_o(runo), .op_mode_field_o(modeo),
        .initial_level_flop_o(tffo), .overflow_irq_enable_o(oveo), .oneshot_select_o(oso),
        .double_buffer_enable_o(dbfo), .filter_interval_field_o(nco),
        .period_compare_o(pco), .toggle_compare_o(tco), .count_o(cnt),
        .filtered_input_o(filt));
    tppg_pin_model far (.core_clk_i(clk), .level_i(lvl), .glitch_i(gl), .pulse_i(pout),
        .pin_o(pin), .edges_o(edges));
    always #4 clk = ~clk;
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // hang guard: whole run needs about 5000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        stk <= (cyc[1:0] == 2'h0);
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    // mode and control written together; mode taken from argument m, 3'h0 once to test the lock
    task automatic ctl(input logic r, input logic o, input logic f, input logic d,
        input logic [1:0] n, input logic [2:0] m);
        @(posedge clk);
        wr <= 1'b1;
        run <= r;
        os <= o;
        tff <= f;
        dbf <= d;
        nc <= n;
        mode <= m;
        @(posedge clk);
        wr <= 1'b0;
        tk(1);
    endtask : ctl
    // low byte first, high byte commits both
    task automatic wc(input logic s, input logic [15:0] v);
        @(posedge clk);
        sel <= s;
        lwr <= 1'b1;
        wd <= v[7:0];
        @(posedge clk);
        lwr <= 1'b0;
        hwr <= 1'b1;
        wd <= v[15:8];
        @(posedge clk);
        hwr <= 1'b0;
        tk(1);
    endtask : wc
    task automatic wfor(input logic w, input logic v, output int t);
        int k;
        k = 0;
        while ((w ? pout : irq) !== v && k < 300) begin
            tk(1);
            k++;
        end
        t = cyc;
        tk(1);
    endtask : wfor
    initial begin
        tk(12);
        arst_n <= 1'b1;
        tk(3);
        chk("pulse_out", {15'h0000, pout}, 16'h0000);
        chk("period_rst", pco, TPPG_CMP_RST);
        wc(1'b0, 16'h0009);
        wc(1'b1, 16'h0003);
        chk("period", pco, 16'h0009);
        chk("toggle", tco, 16'h0003);
        ctl(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, TPPG_MODE_PPG);
        chk("idle_hi", {15'h0000, pout}, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            ls <= fls[i];
            lvl <= 1'b0;
            ctl(1'b0, 1'b0, 1'b1, 1'b0, fn[i], TPPG_MODE_PPG);
            tk(fl[i]);
            chk("filt_lo", {15'h0000, filt}, 16'h0000);
            @(posedge clk);
            lvl <= 1'b1;
            if (fe[i] > 0) begin
                tk(fe[i]);
                chk("filt_early", {15'h0000, filt}, 16'h0000);
            end
            tk(fl[i]);
            chk("filt_hi", {15'h0000, filt}, {15'h0000, fb[i]});
            @(posedge clk);
            gl <= 1'b1;
            @(posedge clk);
            gl <= 1'b0;
            tk(fl[i]);
            chk("filt_glitch", {15'h0000, filt}, {15'h0000, fb[i]});
        end
        @(posedge clk);
        ls <= 1'b0;
        ctl(1'b1, 1'b0, 1'b1, 1'b0, 2'h1, TPPG_MODE_PPG);
        chk("run", {15'h0000, runo}, 16'h0001);
        wfor(1'b0, 1'b1, t0);
        e0 = edges;
        wfor(1'b1, 1'b0, t1);
        wfor(1'b0, 1'b1, t2);
        chk("low_len", 16'(t2 - t1), 16'h0006);
        chk("period_len", 16'(t2 - t0), 16'h000A);
        chk("edges", edges - e0, 16'h0002);
        ctl(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0);
        chk("mode_lock", {13'h0000, modeo}, 16'h0003);
        chk("tff_lock", {14'h0000, tffo, oveo}, 16'h0003);
        chk("nc_lock", {14'h0000, nco}, 16'h0001);
        chk("os_dbf_clr", {14'h0000, oso, dbfo}, 16'h0000);
        wfor(1'b0, 1'b1, t0);
        wc(1'b0, 16'h0013);
        wfor(1'b0, 1'b1, t1);
        chk("direct", 16'(t1 - t0), 16'h0014);
        ctl(1'b1, 1'b0, 1'b1, 1'b1, 2'h1, TPPG_MODE_PPG);
        wfor(1'b0, 1'b1, t0);
        wc(1'b0, 16'h0009);
        chk("buf_read", pco, 16'h0009);
        wfor(1'b0, 1'b1, t1);
        wfor(1'b0, 1'b1, t2);
        chk("buf_old", 16'(t1 - t0), 16'h0014);
        chk("buf_new", 16'(t2 - t1), 16'h000A);
        ctl(1'b1, 1'b1, 1'b1, 1'b1, 2'h1, TPPG_MODE_PPG);
        chk("os_dbf_set", {14'h0000, oso, dbfo}, 16'h0003);
        wfor(1'b0, 1'b1, t0);
        chk("oneshot", {14'h0000, runo, pout}, 16'h0001);
        ctl(1'b1, 1'b1, 1'b1, 1'b1, 2'h1, TPPG_MODE_PPG);
        ctl(1'b1, 1'b0, 1'b1, 1'b1, 2'h1, TPPG_MODE_PPG);
        wfor(1'b0, 1'b1, t0);
        chk("cancel", {15'h0000, runo}, 16'h0001);
        wfor(1'b1, 1'b0, t1);
        ctl(1'b0, 1'b0, 1'b1, 1'b1, 2'h1, TPPG_MODE_PPG);
        chk("stop_lvl", {14'h0000, runo, pout}, 16'h0001);
        chk("stop_cnt", cnt, TPPG_CNT_RST);
        stop_test();
    end
endmodule : timer16_ppg_noise_filter_tb
`default_nettype wire
